//--- hw/cbr_rx_out.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_rx_out
   import cbr_pkg::*;
#(
   parameter int WORD_W = cbr_pkg::CBR_WORD_W,
   parameter int DEPTH = cbr_pkg::CBR_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Cell stream from the receive core
   input wire logic cell_valid,
   output logic cell_ready,
   input wire logic [WORD_W-1:0] cell_word,
   input wire logic cell_first,
   // Configuration
   input wire logic wide_mode,
   input wire logic [cbr_pkg::CBR_ADDR_W-1:0] own_port,
   // Link pins
   input wire logic rx_byte_clock,
   input wire logic rx_read_strobe_n,
   input wire logic [cbr_pkg::CBR_ADDR_W-1:0] rx_port_select,
   output logic [WORD_W-1:0] rx_cell_word,
   output logic rx_cell_word_oe,
   output logic rx_word_parity,
   output logic rx_word_parity_oe,
   output logic rx_cell_first_flag,
   output logic rx_cell_first_flag_oe
);
   import cbr_pkg::*;

   logic [2:0] clk_sync_q;
   logic [1:0] enb_sync_q;
   logic [2*CBR_ADDR_W-1:0] addr_sync_q;
   logic [CBR_ADDR_W-1:0] port_q;
   logic sel_q;
   logic drive_q;
   logic [WORD_W-1:0] word_q;
   logic first_q;
   logic par_q;
   logic edge_rise;
   logic enb_now;
   logic f_valid;
   logic f_ready;
   logic f_first;
   logic [WORD_W-1:0] f_word;
   logic [WORD_W-1:0] eff_word;

   cbr_fifo #(.WIDTH(WORD_W + 1), .DEPTH(DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(cell_valid),
      .in_ready(cell_ready),
      .in_data({cell_first, cell_word}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data({f_first, f_word})
   );

   // Link clock is sampled; only the second and third stages feed edge logic
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk_sync_q <= '0;
         enb_sync_q <= 2'h3;
         addr_sync_q <= '1;
      end else begin
         clk_sync_q <= {clk_sync_q[1:0], rx_byte_clock};
         enb_sync_q <= {enb_sync_q[0], rx_read_strobe_n};
         addr_sync_q <= {addr_sync_q[CBR_ADDR_W-1:0], rx_port_select};
      end
   end

   assign edge_rise = clk_sync_q[1] && !clk_sync_q[2];
   assign enb_now = !enb_sync_q[1];

   // Own address caught after reset release, not under it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         port_q <= CBR_NULL_PORT;
      end else if (port_q == CBR_NULL_PORT) begin
         port_q <= own_port;
      end
   end

   // Selection latched on the link edge where our address is polled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_q <= 1'b0;
      end else if (edge_rise && enb_sync_q[1]) begin
         sel_q <= (addr_sync_q[2*CBR_ADDR_W-1:CBR_ADDR_W] == port_q)
            && (port_q != CBR_NULL_PORT);
      end
   end

   // Drive only in the link cycle that follows an asserted enable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         drive_q <= 1'b0;
      end else if (edge_rise) begin
         drive_q <= enb_now && sel_q;
      end
   end

   assign f_ready = edge_rise && enb_now && sel_q;

   // Narrow mode clears the high octet so it never carries stale bits
   assign eff_word = wide_mode ? f_word
      : {{(WORD_W - CBR_OCTET_W){1'b0}}, f_word[CBR_OCTET_W-1:0]};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         word_q <= '0;
         first_q <= 1'b0;
         par_q <= CBR_PAR_ODD;
      end else if (edge_rise) begin
         if (f_ready && f_valid) begin
            word_q <= eff_word;
            first_q <= f_first;
            par_q <= wide_mode ? (^f_word ^ CBR_PAR_ODD)
               : (^f_word[CBR_OCTET_W-1:0] ^ CBR_PAR_ODD);
         end else begin
            // Underrun: idle word, no cell start, parity still consistent
            word_q <= '0;
            first_q <= 1'b0;
            par_q <= CBR_PAR_ODD;
         end
      end
   end

   assign rx_cell_word = word_q;
   assign rx_cell_first_flag = first_q;
   assign rx_word_parity = par_q;
   assign rx_cell_word_oe = drive_q;
   assign rx_cell_first_flag_oe = drive_q;
   assign rx_word_parity_oe = drive_q;
endmodule
`default_nettype wire

//--- hw/cbr_pkg.sv
package cbr_pkg;
   localparam int CBR_WORD_W = 16;
   localparam int CBR_OCTET_W = 8;
   localparam int CBR_ADDR_W = 5;
   localparam logic [4:0] CBR_NULL_PORT = 5'h1F;
   localparam int CBR_FIFO_DEPTH = 16;
   localparam logic CBR_PAR_ODD = 1'b1;
endpackage

//--- hw/cbr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/cbr_rx_out_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_rx_out_sva #(parameter int WORD_W = 16) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Watched pins
   input wire logic wide_mode,
   input wire logic rx_byte_clock,
   input wire logic rx_read_strobe_n,
   input wire logic [WORD_W-1:0] rx_cell_word,
   input wire logic rx_cell_word_oe,
   input wire logic rx_word_parity,
   input wire logic rx_word_parity_oe,
   input wire logic rx_cell_first_flag_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic oe = rx_cell_word_oe;
   property p_par_oe; oe == rx_word_parity_oe; endproperty
   a_par_oe: assert property (p_par_oe) else $error("parity enable split");
   property p_sof_oe; oe == rx_cell_first_flag_oe; endproperty
   a_sof_oe: assert property (p_sof_oe) else $error("flag enable split");
   property p_par16; oe && wide_mode |-> ^{rx_cell_word, rx_word_parity}; endproperty
   a_par16: assert property (p_par16) else $error("wide parity");
   property p_par8; oe && !wide_mode |-> ^{rx_cell_word[7:0], rx_word_parity}; endproperty
   a_par8: assert property (p_par8) else $error("narrow parity");
   property p_hi0; oe && !wide_mode |-> rx_cell_word[15:8] == 8'h00; endproperty
   a_hi0: assert property (p_hi0) else $error("narrow high octet");
   property p_rst; disable iff (1'b0) rst |=> !oe; endproperty
   a_rst: assert property (p_rst) else $error("drive in reset");
   property p_rise; $rose(oe) |-> !rx_read_strobe_n; endproperty
   a_rise: assert property (p_rise) else $error("drive without enable");
   property p_edge; $changed(oe) |-> rx_byte_clock; endproperty
   a_edge: assert property (p_edge) else $error("drive off link edge");
endmodule
bind cbr_rx_out cbr_rx_out_sva #(.WORD_W(WORD_W)) u_sva (.*);
`default_nettype wire

//--- bench/cbr_atm_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_atm_model (
   // Bench commands
   input wire logic req_n,
   input wire logic [4:0] req_port,
   // Link pins
   output logic rx_byte_clock,
   output logic rx_read_strobe_n,
   output logic [4:0] rx_port_select
);
   initial begin
      rx_byte_clock = 1'b0;
      // Idle bus: strobe released, null port polled
      rx_read_strobe_n = 1'b1;
      rx_port_select = 5'h1F;
      #3;
      forever #80 rx_byte_clock = ~rx_byte_clock;
   end
   // Launch on the falling edge so the rising edge sees settled pins
   always @(negedge rx_byte_clock) begin
      rx_read_strobe_n <= req_n;
      rx_port_select <= req_port;
   end
endmodule
`default_nettype wire

//--- bench/cbr_rx_out_test.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_rx_out_test;
   import cbr_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cell_valid = 1'b0;
   logic cell_first = 1'b0;
   logic wide_mode = 1'b1;
   logic [15:0] cell_word = 16'h0000;
   logic [4:0] own_port = 5'h05;
   logic req_n = 1'b1;
   logic [4:0] req_port = CBR_NULL_PORT;
   logic cell_ready, rx_cell_word_oe, rx_word_parity, rx_word_parity_oe;
   logic rx_cell_first_flag, rx_cell_first_flag_oe, rx_byte_clock, rx_read_strobe_n;
   logic [4:0] rx_port_select;
   logic [15:0] rx_cell_word;
   int errors = 0;
   int cmp_count = 0;
   cbr_rx_out DUT (.*);
   cbr_atm_model atm (.*);
   initial forever #5 sys_clk = ~sys_clk;
   task end_of_test;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [17:0] s, input logic [17:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("ERROR %0t %h %h", $time, s, e);
      end
   endtask
   task push(input logic [15:0] w, input logic f);
      @(posedge sys_clk) cell_valid <= 1'b1;
      cell_word <= w;
      cell_first <= f;
      @(posedge sys_clk) cell_valid <= 1'b0;
      #1;
   endtask
   // One link cycle per call; returns once the pins show this cycle's edge
   task go(input logic n, input logic [4:0] a);
      @(posedge sys_clk) req_n <= n;
      req_port <= a;
      @(negedge rx_byte_clock);
      @(posedge rx_byte_clock);
      repeat (5) @(posedge sys_clk);
   endtask
   task t_stream;
      push(16'hA5C3, 1'b1);
      push(16'h1234, 1'b0);
      push(16'hBE41, 1'b0);
      go(1'b1, own_port);
      go(1'b0, own_port);
      chk({rx_cell_word_oe, rx_cell_first_flag, rx_cell_word}, 18'h3A5C3);
      chk({17'h0, rx_word_parity}, 18'h1);
      go(1'b0, own_port);
      chk({rx_cell_word_oe, rx_cell_first_flag, rx_cell_word}, 18'h21234);
      chk({17'h0, rx_word_parity}, 18'h0);
      go(1'b1, own_port);
      chk({17'h0, rx_cell_word_oe}, 18'h0);
   endtask
   task t_narrow;
      @(posedge sys_clk) wide_mode <= 1'b0;
      go(1'b0, own_port);
      chk({rx_cell_word_oe, rx_cell_first_flag, rx_cell_word}, 18'h20041);
      chk({17'h0, rx_word_parity}, 18'h1);
      go(1'b0, own_port);
      chk({rx_cell_word_oe, rx_cell_first_flag, rx_cell_word}, 18'h20000);
      go(1'b1, own_port);
      chk({17'h0, rx_cell_word_oe}, 18'h0);
   endtask
   task t_unsel;
      go(1'b1, CBR_NULL_PORT);
      go(1'b0, CBR_NULL_PORT);
      go(1'b0, CBR_NULL_PORT);
      chk({17'h0, rx_cell_word_oe}, 18'h0);
   endtask
   task t_fill;
      int n;
      n = 0;
      repeat (20) if (cell_ready) begin
         push(16'h0F0F, 1'b0);
         n++;
      end
      chk(18'(n), 18'h10);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t_stream;
      t_narrow;
      t_unsel;
      t_fill;
      end_of_test;
   end
   initial begin
      #50000;
      errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
